// file: verilog/wps_power_save_wake.sv
// Watchdog, Sleep/Idle sequencing, wake delays and reset-cause flags
`timescale 1ns/1ps
`default_nettype none
`include "wps_regs.svh"

// Functional notes
// - Watchdog counts on RC ticks, ignoring main clock
// - Fuse enable bit one keeps watchdog on
// - Chip erase leaves fuse enable bit at one
// - Overflow outside Sleep and Idle forces device reset
// - Overflow in Sleep wakes, sets sleep, timeout
// - Fuse zero lets software bit gate watchdog
// - Power-save parameter picks Sleep or Idle
// - Sleep stops CPU, peripheral clocks, oscillator
// - Monitor off in Sleep, RC runs with watchdog
// - Brown-out and low-voltage detect stay on
// - Interrupt, reset or overflow ends Sleep
// - Wake restarts prior clock; power resets use fuses
// - Crystal waits start-up, PLL waits lock, delays
// - Non-crystal sources without PLL wake after power-on delay only
// - Running low-power crystal skips start-up delays
// - Interrupt wake services handler, sets sleep flag
// - Clock dead after delays: trap or suspend
// - Non-power-on reset wakes and sets sleep flag
// - Idle stops only the CPU clock
// - Idle wakes instantly, resumes after instruction
// - Idle flag set by wakes and resets
module wps_power_save_wake #(
    parameter int unsigned POWERUP_CYCLES = 640000, // Power-up timer hold
    parameter int unsigned LOCK_CYCLES = 8000 // PLL lock hold
)(
    input wire logic mclk, // System clock, 40 MHz
    input wire logic rst_n, // Power-on reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [25:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic lowPwrRcTick, // One-cycle tick of the RC oscillator
    input wire logic watchdogClearInstr, // Clear instruction executed
    input wire logic powerSaveInstr, // Power-save instruction executed
    input wire logic powerSaveIdle, // Its parameter: 1 Idle, 0 Sleep
    input wire logic wakeInterrupt, // Enabled interrupt at sufficient priority
    input wire logic brownoutReset, // Brown-out detected, pulse
    input wire logic externalResetPin, // External reset pin event, pulse
    input wire logic lowVoltEnable, // Low-voltage detector enabled
    input wire logic oscStartupDone, // Oscillator start-up timer expired
    input wire logic pllLocked, // PLL lock
    input wire logic fuseProgWrite, // Programmer writes one fuse word
    input wire logic [1:0] fuseProgSel, // Fuse word select
    input wire logic [15:0] fuseProgData, // Fuse word value
    input wire logic chipErase, // Programmer chip erase
    output wps_pkg::wps_gate_s clockGates, // Clock and detector enables
    output logic deviceReset, // Internal device reset, level
    output logic serviceInterrupt, // Branch to handler, pulse
    output logic resumeNext, // Resume after power-save instruction, pulse
    output logic clockFailTrap, // Clock failure trap, pulse
    output logic fastRcForce // Fast RC forced on after trap
);
    localparam logic [31:0] POWERON_DELAY_CYC = 32'(`WPS_POWERON_DELAY_CYC);

    function automatic logic regHit(input logic [25:0] a, input logic [23:0] idx);
        return a == {idx, 2'b00};
    endfunction

    function automatic logic [15:0] bitMask(input int unsigned pos);
        return 16'h0001 << pos;
    endfunction

    wps_pkg::wps_state_e state_reg;
    wps_pkg::wps_state_e stateNext;
    wps_pkg::wps_fuse_s fuse_reg;
    wps_pkg::wps_gate_s gateNext;
    logic [15:0] reset_cause_control_reg;
    logic [15:0] rconNext;
    logic [15:0] osc_reg;
    logic [15:0] oscNext;
    logic [1:0] cosc_reg;
    logic [7:0] wdCnt_reg;
    logic [31:0] delayCnt_reg;
    logic powerRst_reg;
    logic wakeByIntr_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    wps_pkg::wps_gate_s gate_reg;
    logic deviceReset_reg;
    logic serviceInterrupt_reg;
    logic resumeNext_reg;
    logic clockFailTrap_reg;
    logic fastRcForce_reg;

    // Bus decode
    wire access = psel && penable;
    wire accept = access && pready_reg;
    wire hitRcon = regHit(paddr, `WPS_IDX_RESET_CAUSE);
    wire hitOsc = regHit(paddr, `WPS_IDX_OSC_CTL);
    wire hitFuseOsc = regHit(paddr, `WPS_IDX_FUSE_OSC);
    wire hitFuseWdog = regHit(paddr, `WPS_IDX_FUSE_WDOG);
    wire hitFuseBrown = regHit(paddr, `WPS_IDX_FUSE_BROWN);
    wire hitFuseCode = regHit(paddr, `WPS_IDX_FUSE_CODESEG);
    wire hitAny = hitRcon | hitOsc | hitFuseOsc | hitFuseWdog | hitFuseBrown | hitFuseCode;
    wire wrRcon = accept && pwrite && hitRcon;
    wire wrOsc = accept && pwrite && hitOsc;

    // Configuration decode
    wire fuseWdogOn = fuse_reg.wdog[`WPS_FZ_WDOG_EN_BIT];
    wire wdogOn = fuseWdogOn | reset_cause_control_reg[`WPS_RC_SOFTWD_BIT];
    wire [1:0] fuseSrc = fuse_reg.osc[`WPS_FZ_SRC_LSB +: 2];
    wire [1:0] clkMon = fuse_reg.osc[`WPS_FZ_CLKMON_LSB +: 2];
    wire clkSwEn = !clkMon[1];
    wire fscmOn = clkMon == 2'b00;
    wire [1:0] wakeOsc = clkSwEn ? cosc_reg : fuseSrc;
    wire primSel = wakeOsc == `WPS_OSC_PRIMARY;
    wire pllUsed = primSel && fuse_reg.osc[`WPS_FZ_PLL_BIT];
    wire lpXtalSel = wakeOsc == `WPS_OSC_LOWPWR_XTAL;
    wire lpXtalKept = osc_reg[`WPS_OC_LPXTAL_EN_BIT];
    // A low-power crystal left running through Sleep needs no start-up hold
    wire oscHold = (primSel && fuse_reg.osc[`WPS_FZ_XTAL_BIT]) || (lpXtalSel && !lpXtalKept);
    wire clkReady = !oscHold || (oscStartupDone && (!pllUsed || pllLocked));
    wire [31:0] wakeDelay = POWERON_DELAY_CYC + (oscHold ? 32'(POWERUP_CYCLES) : 32'h0000_0000)
        + (pllUsed ? 32'(LOCK_CYCLES) : 32'h0000_0000);

    // Events
    wire inSleep = state_reg == wps_pkg::ST_SLEEP;
    wire inIdle = state_reg == wps_pkg::ST_IDLE;
    wire lowPower = inSleep || inIdle;
    // Counter runs only on RC ticks, so a dead main oscillator cannot stop it
    wire wdTimeout = wdogOn && lowPwrRcTick && (wdCnt_reg == `WPS_WD_TOP);
    wire wdReset = wdTimeout && !lowPower;
    wire anyReset = externalResetPin || brownoutReset || wdReset;
    wire wakeAny = lowPower && (wakeInterrupt || wdTimeout);
    wire delayZero = delayCnt_reg == 32'h0000_0000;
    wire trapNow = (state_reg == wps_pkg::ST_DELAY) && delayZero && !clkReady && fscmOn
        && !anyReset;
    wire resumeStep = (stateNext == wps_pkg::ST_RUN) && !trapNow
        && (inIdle || state_reg == wps_pkg::ST_DELAY || state_reg == wps_pkg::ST_WAITCLK);
    wire intrKind = inIdle ? wakeInterrupt : wakeByIntr_reg;
    wire switchNow = (state_reg == wps_pkg::ST_RUN) && osc_reg[`WPS_OC_SWITCH_BIT] && clkSwEn;

    // Reset-cause flags: hardware sets win over a software write in the same cycle
    wire [15:0] hwSet = (externalResetPin ? bitMask(`WPS_RC_EXTRST_BIT) : 16'h0000)
        | (brownoutReset ? bitMask(`WPS_RC_BROWNOUT_BIT) : 16'h0000)
        | (wdTimeout ? bitMask(`WPS_RC_WDTIMEOUT_BIT) : 16'h0000)
        | ((anyReset || wakeAny) && inSleep ? bitMask(`WPS_RC_SLEEP_BIT) : 16'h0000)
        | ((anyReset || wakeAny) && inIdle ? bitMask(`WPS_RC_IDLE_BIT) : 16'h0000);
    wire [15:0] hwClr = (externalResetPin ? bitMask(`WPS_RC_WDTIMEOUT_BIT) : 16'h0000)
        | (externalResetPin && !lowPower ? bitMask(`WPS_RC_SWRST_BIT) : 16'h0000)
        | (wdReset ? (bitMask(`WPS_RC_EXTRST_BIT) | bitMask(`WPS_RC_SWRST_BIT)) : 16'h0000)
        | (brownoutReset ? bitMask(`WPS_RC_POWERON_BIT) : 16'h0000)
        | ((externalResetPin || wdReset) && !inSleep ? bitMask(`WPS_RC_SLEEP_BIT) : 16'h0000)
        | ((externalResetPin || wdReset) && !inIdle ? bitMask(`WPS_RC_IDLE_BIT) : 16'h0000);
    wire [15:0] rconBase = wrRcon ? ((pwdata[15:0] & `WPS_RC_WRITE_MASK)
        | (reset_cause_control_reg & ~`WPS_RC_WRITE_MASK)) : reset_cause_control_reg;
    assign rconNext = (rconBase & ~hwClr) | hwSet;

    wire [15:0] oscBase = wrOsc ? (pwdata[15:0] & `WPS_OC_WRITE_MASK) : osc_reg;
    wire [15:0] oscHwClr = switchNow ? bitMask(`WPS_OC_SWITCH_BIT) : 16'h0000;
    wire [15:0] oscHwSet = trapNow ? bitMask(`WPS_OC_CLKFAIL_BIT) : 16'h0000;
    assign oscNext = (oscBase & ~oscHwClr) | oscHwSet;
    wire [15:0] oscView = osc_reg | {2'b00, cosc_reg, 12'h000}
        | (pllLocked ? bitMask(`WPS_OC_LOCK_BIT) : 16'h0000);

    wire [15:0] readHalf = hitRcon ? reset_cause_control_reg
        : hitOsc ? oscView
        : hitFuseOsc ? fuse_reg.osc
        : hitFuseWdog ? fuse_reg.wdog
        : hitFuseBrown ? fuse_reg.brown
        : hitFuseCode ? fuse_reg.codeSeg
        : 16'h0000;

    // Power state sequencing
    always_comb
    begin
        stateNext = state_reg;
        unique case (state_reg)
            wps_pkg::ST_RESET:
                if (delayZero)
                    stateNext = wps_pkg::ST_RUN;
            wps_pkg::ST_RUN:
                if (powerSaveInstr)
                    stateNext = powerSaveIdle ? wps_pkg::ST_IDLE : wps_pkg::ST_SLEEP;
            wps_pkg::ST_IDLE:
                if (wakeAny)
                    stateNext = wps_pkg::ST_RUN;
            wps_pkg::ST_SLEEP:
                if (wakeAny)
                    stateNext = wps_pkg::ST_DELAY;
            wps_pkg::ST_DELAY:
                if (delayZero)
                    stateNext = (clkReady || fscmOn) ? wps_pkg::ST_RUN : wps_pkg::ST_WAITCLK;
            wps_pkg::ST_WAITCLK:
                if (clkReady)
                    stateNext = wps_pkg::ST_RUN;
            default:
                stateNext = wps_pkg::ST_RESET;
        endcase
        if (anyReset)
            stateNext = wps_pkg::ST_RESET;
    end

    // Gate values follow the state being entered so outputs stay registered
    wire nxSleep = stateNext == wps_pkg::ST_SLEEP;
    always_comb
    begin
        gateNext.cpuClk = stateNext == wps_pkg::ST_RUN;
        gateNext.periphClk = (stateNext == wps_pkg::ST_RUN) || (stateNext == wps_pkg::ST_IDLE);
        gateNext.primaryOsc = (cosc_reg == `WPS_OSC_PRIMARY) && !nxSleep;
        gateNext.lowPwrXtal = ((cosc_reg == `WPS_OSC_LOWPWR_XTAL) && !nxSleep) || lpXtalKept;
        gateNext.lowPwrRc = wdogOn || (fscmOn && !nxSleep)
            || ((cosc_reg == `WPS_OSC_LOWPWR_RC) && !nxSleep);
        gateNext.failsafeMon = fscmOn && !nxSleep;
        gateNext.brownout = fuse_reg.brown[`WPS_FZ_BROWN_EN_BIT];
        gateNext.lowVolt = lowVoltEnable;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= wps_pkg::ST_RESET;
            delayCnt_reg <= POWERON_DELAY_CYC;
            powerRst_reg <= 1'b1;
            wakeByIntr_reg <= 1'b0;
        end
        else
        begin
            state_reg <= stateNext;
            if (anyReset)
                delayCnt_reg <= POWERON_DELAY_CYC;
            else if (inSleep && wakeAny)
                delayCnt_reg <= wakeDelay;
            else if (!delayZero)
                delayCnt_reg <= delayCnt_reg - 32'h0000_0001;
            if (brownoutReset)
                powerRst_reg <= 1'b1;
            else if (anyReset || state_reg == wps_pkg::ST_RUN)
                powerRst_reg <= 1'b0;
            if (wakeAny)
                wakeByIntr_reg <= wakeInterrupt;
        end
    end

    // Watchdog counter
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wdCnt_reg <= 8'h00;
        else if (watchdogClearInstr || anyReset || !wdogOn)
            wdCnt_reg <= 8'h00;
        else if (lowPwrRcTick)
            wdCnt_reg <= wdCnt_reg + 8'h01;
    end

    // Fuses: erased to all ones, changed only by the programmer port
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            fuse_reg <= {4{`WPS_FZ_ERASED}};
        else if (chipErase)
            fuse_reg <= {4{`WPS_FZ_ERASED}};
        else if (fuseProgWrite)
        begin
            unique case (fuseProgSel)
                2'h0: fuse_reg.osc <= fuseProgData;
                2'h1: fuse_reg.wdog <= fuseProgData;
                2'h2: fuse_reg.brown <= fuseProgData;
                2'h3: fuse_reg.codeSeg <= fuseProgData;
            endcase
        end
    end

    // Control registers and clock selection
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reset_cause_control_reg <= `WPS_RC_POR_VALUE;
            osc_reg <= `WPS_OC_RESET_VALUE;
            cosc_reg <= `WPS_OSC_FAST_RC;
            fastRcForce_reg <= 1'b0;
        end
        else
        begin
            reset_cause_control_reg <= rconNext;
            osc_reg <= oscNext;
            if (state_reg == wps_pkg::ST_RESET && powerRst_reg)
                cosc_reg <= fuseSrc;
            else if (trapNow)
                cosc_reg <= `WPS_OSC_FAST_RC;
            else if (switchNow)
                cosc_reg <= osc_reg[`WPS_OC_NEW_LSB +: 2];
            fastRcForce_reg <= !anyReset && (trapNow || (fastRcForce_reg && !switchNow));
        end
    end

    // Registered outputs
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_reg <= '0;
            deviceReset_reg <= 1'b1;
            serviceInterrupt_reg <= 1'b0;
            resumeNext_reg <= 1'b0;
            clockFailTrap_reg <= 1'b0;
        end
        else
        begin
            gate_reg <= gateNext;
            deviceReset_reg <= stateNext == wps_pkg::ST_RESET;
            serviceInterrupt_reg <= resumeStep && intrKind;
            resumeNext_reg <= resumeStep && !intrKind;
            clockFailTrap_reg <= trapNow;
        end
    end

    // APB slave: one wait state, read data and error launched with pready
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && !hitAny;
            if (access && !pready_reg)
                prdata_reg <= {16'h0000, readHalf};
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign clockGates = gate_reg;
    assign deviceReset = deviceReset_reg;
    assign serviceInterrupt = serviceInterrupt_reg;
    assign resumeNext = resumeNext_reg;
    assign clockFailTrap = clockFailTrap_reg;
    assign fastRcForce = fastRcForce_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_wdReset;
        wdReset |=> deviceReset ##1 deviceReset;
    endproperty
    a_wdReset: assert property (p_wdReset) else $error("overflow did not reset");

    property p_sleepWake;
        (inSleep && wdTimeout && !externalResetPin && !brownoutReset) |=>
            reset_cause_control_reg[`WPS_RC_SLEEP_BIT] && reset_cause_control_reg[`WPS_RC_WDTIMEOUT_BIT] && !deviceReset;
    endproperty
    a_sleepWake: assert property (p_sleepWake) else $error("sleep overflow flags wrong");

    property p_sleepGates;
        inSleep |-> !clockGates.cpuClk && !clockGates.periphClk && !clockGates.failsafeMon;
    endproperty
    a_sleepGates: assert property (p_sleepGates) else $error("clocks running in sleep");

    property p_idleGates;
        inIdle |-> !clockGates.cpuClk && clockGates.periphClk
            && (clockGates.failsafeMon == fscmOn);
    endproperty
    a_idleGates: assert property (p_idleGates) else $error("idle gating wrong");

    property p_fuseKeepsCount;
        (fuseWdogOn && lowPwrRcTick && !watchdogClearInstr && !anyReset
            && wdCnt_reg != `WPS_WD_TOP) |=> wdCnt_reg == $past(wdCnt_reg) + 8'h01;
    endproperty
    a_fuseKeepsCount: assert property (p_fuseKeepsCount) else $error("watchdog stalled");

    property p_clear;
        watchdogClearInstr |=> wdCnt_reg == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero counter");

    property p_erase;
        chipErase |=> fuse_reg.wdog[`WPS_FZ_WDOG_EN_BIT] && wdogOn;
    endproperty
    a_erase: assert property (p_erase) else $error("erase left watchdog off");

    property p_idleWake;
        (inIdle && wakeInterrupt && !anyReset) |=> clockGates.cpuClk && serviceInterrupt
            && reset_cause_control_reg[`WPS_RC_IDLE_BIT];
    endproperty
    a_idleWake: assert property (p_idleWake) else $error("idle wake not immediate");

    property p_wakeHold;
        (inSleep && wakeAny && !anyReset) |=> !clockGates.cpuClk [*8];
    endproperty
    a_wakeHold: assert property (p_wakeHold) else $error("sleep wake too fast");

    property p_trap;
        trapNow |=> clockFailTrap && fastRcForce && cosc_reg == `WPS_OSC_FAST_RC;
    endproperty
    a_trap: assert property (p_trap) else $error("no clock failure trap");

    property p_brownSleep;
        (inSleep && $stable(fuse_reg.brown)) |-> clockGates.brownout
            == fuse_reg.brown[`WPS_FZ_BROWN_EN_BIT];
    endproperty
    a_brownSleep: assert property (p_brownSleep) else $error("brown-out off in sleep");
endmodule // wps_power_save_wake
`default_nettype wire

// file: pkg/wps_regs.svh
// Offsets, field positions, reset values and timing counts of the power-save controller
`ifndef WPS_REGS_SVH
`define WPS_REGS_SVH

// Register indices; the bus byte address is four times the index
`define WPS_IDX_RESET_CAUSE 24'h00_0740
`define WPS_IDX_OSC_CTL 24'h00_0742
`define WPS_IDX_FUSE_OSC 24'hF8_0000
`define WPS_IDX_FUSE_WDOG 24'hF8_0002
`define WPS_IDX_FUSE_BROWN 24'hF8_0004
`define WPS_IDX_FUSE_CODESEG 24'hF8_000A

// Reset cause and control fields
`define WPS_RC_TRAP_BIT 15
`define WPS_RC_ILLOP_BIT 14
`define WPS_RC_EXTRST_BIT 7
`define WPS_RC_SWRST_BIT 6
`define WPS_RC_SOFTWD_BIT 5
`define WPS_RC_WDTIMEOUT_BIT 4
`define WPS_RC_SLEEP_BIT 3
`define WPS_RC_IDLE_BIT 2
`define WPS_RC_BROWNOUT_BIT 1
`define WPS_RC_POWERON_BIT 0
`define WPS_RC_WRITE_MASK 16'hC0FF
`define WPS_RC_POR_VALUE 16'h0003

// Oscillator control fields
`define WPS_OC_CUR_LSB 12
`define WPS_OC_NEW_LSB 8
`define WPS_OC_LOCK_BIT 5
`define WPS_OC_CLKFAIL_BIT 3
`define WPS_OC_LPXTAL_EN_BIT 1
`define WPS_OC_SWITCH_BIT 0
`define WPS_OC_WRITE_MASK 16'hCFCB
`define WPS_OC_RESET_VALUE 16'h0000

// Fuse fields and erased value
`define WPS_FZ_ERASED 16'hFFFF
`define WPS_FZ_WDOG_EN_BIT 15
`define WPS_FZ_CLKMON_LSB 14
`define WPS_FZ_SRC_LSB 8
`define WPS_FZ_PLL_BIT 3
`define WPS_FZ_XTAL_BIT 2
`define WPS_FZ_BROWN_EN_BIT 7

// Clock source codes
`define WPS_OSC_FAST_RC 2'h0
`define WPS_OSC_LOWPWR_RC 2'h1
`define WPS_OSC_LOWPWR_XTAL 2'h2
`define WPS_OSC_PRIMARY 2'h3

// Watchdog counter and timing
`define WPS_WD_TOP 8'hFF
`define WPS_MCLK_MHZ 40
`define WPS_POWERON_DELAY_NS 10000
`define WPS_POWERON_DELAY_CYC ((`WPS_POWERON_DELAY_NS * `WPS_MCLK_MHZ + 999) / 1000)

`endif

// file: pkg/wps_pkg.sv
// Types shared by the watchdog and power-save controller
package wps_pkg;
    typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_IDLE, ST_SLEEP, ST_DELAY, ST_WAITCLK} wps_state_e;

    typedef struct packed {
        logic [15:0] codeSeg;
        logic [15:0] brown;
        logic [15:0] wdog;
        logic [15:0] osc;
    } wps_fuse_s;

    typedef struct packed {
        logic cpuClk;
        logic periphClk;
        logic primaryOsc;
        logic lowPwrXtal;
        logic lowPwrRc;
        logic failsafeMon;
        logic brownout;
        logic lowVolt;
    } wps_gate_s;
endpackage

// file: tb/wps_power_save_wake_tb.sv
// Self-checking bench for the watchdog and power-save controller
`timescale 1ns/1ps
`default_nettype none
module wps_power_save_wake_tb;
    localparam logic [25:0] RC_ADDR = 26'h000_1D00;
    localparam logic [25:0] FWD_ADDR = 26'h3E0_0008;
    localparam logic [25:0] OSC_ADDR = 26'h000_1D08;
    logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [25:0] paddr = 26'h000_0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, slvErr, tick = 1'h0, clr = 1'h0, ps = 1'h0, psIdle = 1'h0;
    logic wake = 1'h0, extRst = 1'h0, fpw = 1'h0, devRst, svc, rsm, trap, fast_rc_osc;
    logic oscOk = 1'h1, erase = 1'h0;
    logic [1:0] fsel = 2'h0;
    logic [15:0] fdata = 16'h0000;
    wps_pkg::wps_gate_s gates;
    int errors = 0, n_compared = 0, n;

    // Short power-up and lock holds keep the Sleep wake near 431 cycles
    wps_power_save_wake #(.POWERUP_CYCLES(20), .LOCK_CYCLES(10)) wps_power_save_wake_i (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lowPwrRcTick(tick), .watchdogClearInstr(clr), .powerSaveInstr(ps),
        .powerSaveIdle(psIdle), .wakeInterrupt(wake), .brownoutReset(1'h0),
        .externalResetPin(extRst), .lowVoltEnable(1'h0), .oscStartupDone(oscOk),
        .pllLocked(1'h1), .fuseProgWrite(fpw), .fuseProgSel(fsel), .fuseProgData(fdata),
        .chipErase(erase), .clockGates(gates), .deviceReset(devRst),
        .serviceInterrupt(svc), .resumeNext(rsm), .clockFailTrap(trap), .fastRcForce(fast_rc_osc));

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task apb(input logic wr, input logic [25:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1)
        begin
            errors++;
            $display("Error at %0t: bus transfer not answered", $time);
        end
        q = prdata;
        slvErr = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask

    task ticks(input int cnt);
        repeat (cnt)
        begin
            @(posedge mclk) tick <= 1'h1;
            @(posedge mclk) tick <= 1'h0;
        end
    endtask

    task pwrSave(input logic idle);
        @(posedge mclk) ps <= 1'h1;
        psIdle <= idle;
        @(posedge mclk) ps <= 1'h0;
        repeat (2) @(posedge mclk);
    endtask

    // Sel 0 waits for reset release, sel 1 for a wake pulse, sel 2 for a clock failure trap
    task waitEv(input int sel);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while ((sel == 2 ? !trap : sel == 1 ? !(svc | rsm) : devRst) && n < 2000);
        if (n >= 2000)
        begin
            errors++;
            $display("Error at %0t: wait for event timed out", $time);
        end
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'h1;
        waitEv(0);
        apb(1'h0, RC_ADDR, 32'h0); check(q, 32'h0000_0003);
        apb(1'h0, FWD_ADDR, 32'h0); check(q, 32'h0000_FFFF);
        apb(1'h0, 26'h000_0010, 32'h0); check(slvErr, 32'h1);
        apb(1'h1, RC_ADDR, 32'h0);
        ticks(255);
        @(posedge mclk) clr <= 1'h1;
        @(posedge mclk) clr <= 1'h0;
        ticks(255); check(devRst, 32'h0);
        ticks(1);
        @(posedge mclk); check(devRst, 32'h1);
        waitEv(0);
        apb(1'h0, RC_ADDR, 32'h0); check(q[4], 32'h1);
        // Idle: only the CPU clock stops and wake is immediate
        apb(1'h1, RC_ADDR, 32'h0);
        pwrSave(1'h1); check({gates.cpuClk, gates.periphClk}, 32'h1);
        @(posedge mclk) wake <= 1'h1;
        waitEv(1); check({svc, gates.cpuClk}, 32'h3);
        wake <= 1'h0;
        apb(1'h0, RC_ADDR, 32'h0); check(q[2], 32'h1);
        // Sleep: crystal with PLL from erased fuses needs the full hold
        apb(1'h1, RC_ADDR, 32'h0);
        pwrSave(1'h0);
        check({gates.cpuClk, gates.periphClk, gates.lowPwrRc, gates.brownout}, 32'h3);
        @(posedge mclk) wake <= 1'h1;
        waitEv(1); check(n > 425 && n < 436, 32'h1);
        check(svc, 32'h1);
        wake <= 1'h0;
        apb(1'h0, RC_ADDR, 32'h0); check(q[3], 32'h1);
        apb(1'h1, RC_ADDR, 32'h0);
        @(posedge mclk) clr <= 1'h1;
        @(posedge mclk) clr <= 1'h0;
        pwrSave(1'h0);
        ticks(256);
        waitEv(1); check({rsm, devRst}, 32'h2);
        apb(1'h0, RC_ADDR, 32'h0); check(q[4:3], 32'h3);
        apb(1'h1, RC_ADDR, 32'h0);
        pwrSave(1'h0);
        @(posedge mclk) extRst <= 1'h1;
        @(posedge mclk) extRst <= 1'h0;
        waitEv(0);
        apb(1'h0, RC_ADDR, 32'h0); check(q[7:0] & 8'h88, 32'h88);
        // Fuse cleared: the software bit alone gates the watchdog
        @(posedge mclk) fpw <= 1'h1;
        fsel <= 2'h1; fdata <= 16'h7FFF;
        @(posedge mclk) fpw <= 1'h0;
        apb(1'h1, RC_ADDR, 32'h0);
        ticks(256); check(devRst, 32'h0);
        apb(1'h1, RC_ADDR, 32'h0000_0020);
        ticks(256);
        @(posedge mclk); check(devRst, 32'h1);
        // Monitor on and crystal never starts: the Sleep wake ends in a trap
        waitEv(0);
        apb(1'h1, RC_ADDR, 32'h0);
        @(posedge mclk) fpw <= 1'h1;
        fsel <= 2'h0; fdata <= 16'h3FFF; oscOk <= 1'h0;
        @(posedge mclk) fpw <= 1'h0;
        pwrSave(1'h0);
        @(posedge mclk) wake <= 1'h1;
        waitEv(2); check({trap, fast_rc_osc, gates.cpuClk, n > 425 && n < 436}, 32'hF);
        wake <= 1'h0;
        apb(1'h0, OSC_ADDR, 32'h0); check({q[13:12], q[3]}, 32'h1);
        // Low-power crystal kept through Sleep: only the power-on delay
        apb(1'h1, OSC_ADDR, 32'h0000_0203);
        pwrSave(1'h0); check({gates.lowPwrXtal, gates.primaryOsc}, 32'h2);
        @(posedge mclk) wake <= 1'h1;
        waitEv(1); check({n > 398 && n < 406, fast_rc_osc}, 32'h2);
        wake <= 1'h0;
        @(posedge mclk) erase <= 1'h1;
        @(posedge mclk) erase <= 1'h0;
        apb(1'h0, FWD_ADDR, 32'h0); check(q, 32'h0000_FFFF);
        stop_test;
    end

    initial
    begin
        repeat (30000) @(posedge mclk);
        errors++;
        stop_test;
    end
endmodule // wps_power_save_wake_tb
`default_nettype wire
